// [adc_host_model.sv]
/*
 Host controller model for the converter serial port: chip select, SCK
 and SDI are driven here, SDO is sampled here.
 Assumes the host owns SCK (slave mode) with a 125 ns link period.
*/
`timescale 1ns/1ps
module adc_host_model (
	input wire logic sdo_i,
	input wire logic sdo_oe_i,
	output logic cs_n_o,
	output logic sck_o,
	output logic sdi_o
);
	logic sdo_seen = 1'b0;
	logic sdo_w;

	// Released SDO reads as the inverse of its last driven level
	always @*
	begin
		if (sdo_oe_i)
			sdo_seen = sdo_i;
	end
	assign sdo_w = sdo_oe_i ? sdo_i : ~sdo_seen;

	initial
	begin
		cs_n_o = 1'b1;
		sck_o = 1'b0;
		sdi_o = 1'b0;
	end

	// chip select low, SCK held low
	task automatic select();
		#17;
		cs_n_o = 1'b0;
		#250;
	endtask : select

	task automatic clock_bits(input logic [15:0] cfg, input int n,
		output logic [23:0] rd, output logic tail);
		rd = 24'h000000;
		for (int k = 1; k <= n; k++)
		begin
			// SDI set up before the rising edge
			sdi_o = (k <= 16) ? cfg[16 - k] : ~sdi_o;
			#62.5;
			sck_o = 1'b1;
			rd[24 - k] = sdo_w;
			#62.5;
			sck_o = 1'b0;
		end
		#20;
		tail = sdo_w;
	endtask : clock_bits

	task automatic release_cs();
		#30;
		cs_n_o = 1'b1;
		sdi_o = ~sdi_o;
	endtask : release_cs

	// SCK activity with chip select high, which must be ignored
	task automatic sck_noise(input int n);
		repeat (n)
		begin
			#62.5;
			sck_o = 1'b1;
			#62.5;
			sck_o = 1'b0;
		end
	endtask : sck_noise
endmodule : adc_host_model

// [adc_link_if.sv]
/*
 Signals between the converter core and its SCK-clocked shifter.
 Assumes word is held stable while a frame runs.
*/
`timescale 1ns/1ps
interface adc_link_if;
	logic cs_n;
	logic sdi;
	logic [23:0] word;
	logic sdo_bit;
	logic shift_on;
	logic rise_tgl;
	logic done_tgl;
	logic cfg_tgl;
	logic [15:0] cfg_word;

	modport core (
		output cs_n, sdi, word,
		input sdo_bit, shift_on, rise_tgl, done_tgl, cfg_tgl, cfg_word
	);
	modport link (
		input cs_n, sdi, word,
		output sdo_bit, shift_on, rise_tgl, done_tgl, cfg_tgl, cfg_word
	);
endinterface : adc_link_if

// [adc_link_shifter.sv]
/*
 SCK-domain shifter: counts frame edges, shifts the result word out on
 falling edges and the configuration word in on rising edges.
 Assumes SCK idles low; SCK edges while chip select is high are ignored.
*/
`timescale 1ns/1ps
`include "adc_port_regs.svh"
module adc_link_shifter (
	input wire logic sck_i,
	input wire logic rst_i,
	adc_link_if.link lnk
);
	logic [4:0] rise_cnt;
	logic [4:0] fall_cnt;
	logic [15:0] in_sr;

	// ----------------------------------------
	// Rising edges
	// ----------------------------------------
	// edges ignored
	always_ff @(posedge sck_i or posedge lnk.cs_n)
	begin
		if (lnk.cs_n)
		begin
			rise_cnt <= 5'h00;
			in_sr <= 16'h0000;
		end
		else
		begin
			if (rise_cnt != `WORD_BITS)
				rise_cnt <= rise_cnt + 5'h01;
			if (rise_cnt < `CFG_BITS)
				in_sr <= {in_sr[14:0], lnk.sdi};
		end
	end

	// Toggles survive chip select; the core side sees every event
	always_ff @(posedge sck_i or posedge rst_i)
	begin
		if (rst_i)
		begin
			lnk.rise_tgl <= 1'b0;
			lnk.done_tgl <= 1'b0;
			lnk.cfg_tgl <= 1'b0;
			lnk.cfg_word <= 16'h0000;
		end
		else if (!lnk.cs_n)
		begin
			if (rise_cnt == 5'h00)
				lnk.rise_tgl <= ~lnk.rise_tgl;
			if (rise_cnt == `CFG_BITS - 5'h01)
			begin
				lnk.cfg_word <= {in_sr[14:0], lnk.sdi};
				lnk.cfg_tgl <= ~lnk.cfg_tgl;
			end
			if (rise_cnt == `WORD_BITS - 5'h01)
				lnk.done_tgl <= ~lnk.done_tgl;
		end
	end

	// ----------------------------------------
	// Falling edges
	// ----------------------------------------
	// update on fall
	always_ff @(negedge sck_i or posedge lnk.cs_n)
	begin
		if (lnk.cs_n)
		begin
			fall_cnt <= 5'h00;
			lnk.shift_on <= 1'b0;
			lnk.sdo_bit <= 1'b1;
		end
		else
		begin
			lnk.shift_on <= 1'b1;
			if (fall_cnt != `WORD_BITS)
				fall_cnt <= fall_cnt + 5'h01;
			if (fall_cnt > `LAST_DATA_FALL)
				lnk.sdo_bit <= 1'b1;
			else
				lnk.sdo_bit <= lnk.word[`LAST_DATA_FALL - fall_cnt];
		end
	end

	property p_after_fall(logic [4:0] at, logic lvl);
		@(negedge sck_i) disable iff (lnk.cs_n)
		fall_cnt == at |=> lnk.sdo_bit == lvl;
	endproperty

	a_filler_low: assert property (p_after_fall(5'h00, 1'b0))
		else $error("filler bit not low");
	a_next_eoc_high: assert property (p_after_fall(`TAIL_FALL, 1'b1))
		else $error("output not high after last bit");
	a_tail_zeros: assert property (@(negedge sck_i) disable iff (lnk.cs_n)
		fall_cnt >= `ZERO_TAIL_FALL && fall_cnt <= `LAST_DATA_FALL
		|=> !lnk.sdo_bit)
		else $error("trailing bits not low");

endmodule : adc_link_shifter

// [adc_port_pkg.sv]
/*
 Types of the converter serial result port: states and selections.
 Assumes nothing of its surroundings.
*/
package adc_port_pkg;

	typedef enum logic [3:0] {
		ST_START = 4'h1,
		ST_CONVERT = 4'h2,
		ST_SLEEP = 4'h4,
		ST_OUTPUT = 4'h8
	} state_t;

	typedef struct packed {
		logic single_ended_select;
		logic odd_polarity;
		logic channel_addr_bit2;
		logic channel_addr_bit1;
		logic channel_addr_bit0;
	} chan_t;

	typedef struct packed {
		logic temp_sensor_select;
		logic rejection_sel_a;
		logic rejection_sel_b;
		logic double_rate_select;
		logic gain_sel_bit2;
		logic gain_sel_bit1;
		logic gain_sel_bit0;
	} conv_cfg_t;

endpackage : adc_port_pkg

// [adc_port_regs.svh]
/*
 Constants of the converter serial result port: word layout, input word
 fields, reset values and timing figures.
 Assumes inclusion by its bare name from the design files.
*/
`ifndef ADC_PORT_REGS_SVH
`define ADC_PORT_REGS_SVH

// ----------------------------------------
// Output word
// ----------------------------------------
`define WORD_BITS 5'h18
`define TAIL_FALL 5'h17
`define LAST_DATA_FALL 5'h16
`define ZERO_TAIL_FALL 5'h13
`define OVER_CODE 18'h30000
`define UNDER_CODE 18'h0ffff
`define WORD_RST 24'h000000

// ----------------------------------------
// Input word
// ----------------------------------------
`define CFG_BITS 5'h10
`define PRE_HI 15
`define PRE_LO 13
`define PRE_UPDATE 3'h5
`define CHAN_HI 12
`define CHAN_LO 8
`define EN2_BIT 7
`define CFG_HI 6
`define CFG_LO 0
`define CHAN_RST 5'h00
`define CFG_RST 7'h00

// ----------------------------------------
// Timing
// ----------------------------------------
`define CLK_PERIOD_NS 50
`define CONV_TIME_US 1000
`define SCK_HALF_NS 500

`endif

// [adc_serial_result_port.sv]
/*
 Serial result port of a delta-sigma converter: conversion timing,
 result word build, configuration intake and the SCK master generator.
 Assumes the analog core on clk_i and a pad that resolves SCK and SDO.
*/
`timescale 1ns/1ps
`include "adc_port_regs.svh"
module adc_serial_result_port #(
	parameter int CONV_CYCLES =
		(`CONV_TIME_US * 1000 + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS
) (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic sck_i,
	output logic sck_o,
	output logic sck_oe_o,
	input wire logic cs_n_i,
	input wire logic sdi_i,
	output logic sdo_o,
	output logic sdo_oe_o,
	input wire logic ext_conversion_clock_i,
	input wire logic ext_clock_sel_i,
	input wire logic [16:0] result_i,
	input wire logic over_range_i,
	input wire logic under_range_i,
	output logic conv_start_o,
	output logic sleep_o,
	output logic slave_mode_o,
	output adc_port_pkg::chan_t channel_sel_o,
	output adc_port_pkg::conv_cfg_t conv_cfg_o
);
	localparam int SCK_HALF =
		(`SCK_HALF_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS;
	localparam logic [31:0] CONV_LAST = 32'(CONV_CYCLES - 1);
	localparam logic [3:0] HALF_LAST = 4'(SCK_HALF - 1);

	adc_port_pkg::state_t st;
	adc_port_pkg::chan_t pend_chan;
	adc_port_pkg::conv_cfg_t pend_cfg;
	logic [2:0] cs_s;
	logic [1:0] sck_s;
	logic [2:0] ext_s;
	logic [2:0] rise_s;
	logic [2:0] done_s;
	logic [2:0] cfg_s;
	logic cs_rise;
	logic cs_fall;
	logic rise_evt;
	logic done_evt;
	logic cfg_evt;
	logic tick;
	logic conv_end;
	logic started;
	logic eoc;
	logic [31:0] cnt;
	logic [23:0] res_word;
	logic [1:0] boot;
	logic [3:0] hc;
	logic [4:0] pulses;

	adc_link_if lnk ();

	adc_link_shifter u_shifter (
		.sck_i(sck_i),
		.rst_i(rst_i),
		.lnk(lnk.link)
	);

	// ----------------------------------------
	// Helpers
	// ----------------------------------------
	function automatic logic toggled(input logic [2:0] s);
		toggled = s[1] ^ s[2];
	endfunction : toggled

	function automatic logic [23:0] build_word(input logic [16:0] v,
		input logic ov, input logic un);
		logic [17:0] code;
		code = {~v[16], v};
		if (ov)
			code = `OVER_CODE;
		else if (un)
			code = `UNDER_CODE;
		build_word = {1'b0, 1'b0, code, 4'h0};
	endfunction : build_word

	// ----------------------------------------
	// Crossings
	// ----------------------------------------
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			cs_s <= 3'h7;
			sck_s <= 2'h0;
			ext_s <= 3'h0;
			rise_s <= 3'h0;
			done_s <= 3'h0;
			cfg_s <= 3'h0;
		end
		else
		begin
			cs_s <= {cs_s[1:0], cs_n_i};
			sck_s <= {sck_s[0], sck_i};
			ext_s <= {ext_s[1:0], ext_conversion_clock_i};
			rise_s <= {rise_s[1:0], lnk.rise_tgl};
			done_s <= {done_s[1:0], lnk.done_tgl};
			cfg_s <= {cfg_s[1:0], lnk.cfg_tgl};
		end
	end

	assign lnk.cs_n = cs_n_i;
	assign lnk.sdi = sdi_i;
	assign lnk.word = res_word;
	assign cs_rise = cs_s[1] & ~cs_s[2];
	assign cs_fall = ~cs_s[1] & cs_s[2];
	assign rise_evt = toggled(rise_s);
	assign done_evt = toggled(done_s);
	assign cfg_evt = toggled(cfg_s);

	assign tick = ~ext_clock_sel_i | (ext_s[1] & ~ext_s[2]);
	assign conv_end = st == adc_port_pkg::ST_CONVERT && tick &&
		cnt == CONV_LAST;

	// ----------------------------------------
	// Conversion cycle
	// ----------------------------------------
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
			st <= adc_port_pkg::ST_START;
		else
		begin
			case (st)
				adc_port_pkg::ST_START:
					st <= adc_port_pkg::ST_CONVERT;
				adc_port_pkg::ST_CONVERT:
					if (conv_end)
						st <= cs_s[1] ? adc_port_pkg::ST_SLEEP :
							adc_port_pkg::ST_OUTPUT;
				adc_port_pkg::ST_SLEEP:
					if (cs_fall)
						st <= adc_port_pkg::ST_OUTPUT;
				adc_port_pkg::ST_OUTPUT:
					if (done_evt)
						st <= adc_port_pkg::ST_START;
					else if (cs_rise)
						st <= (started | rise_evt) ?
							adc_port_pkg::ST_START :
							adc_port_pkg::ST_SLEEP;
				default:
					st <= adc_port_pkg::ST_START;
			endcase
		end
	end

	// Counted only in the output state so stray clocks do no harm
	always_ff @(posedge clk_i)
	begin
		if (rst_i || st != adc_port_pkg::ST_OUTPUT)
			started <= 1'b0;
		else if (rise_evt)
			started <= 1'b1;
	end

	always_ff @(posedge clk_i)
	begin
		if (rst_i || st == adc_port_pkg::ST_START)
			cnt <= 32'h00000000;
		else if (st == adc_port_pkg::ST_CONVERT && tick && !conv_end)
			cnt <= cnt + 32'h00000001;
	end

	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			conv_start_o <= 1'b0;
			eoc <= 1'b1;
			sleep_o <= 1'b0;
		end
		else
		begin
			conv_start_o <= st == adc_port_pkg::ST_START;
			eoc <= !(st == adc_port_pkg::ST_SLEEP ||
				st == adc_port_pkg::ST_OUTPUT);
			sleep_o <= st == adc_port_pkg::ST_SLEEP;
		end
	end

	// ----------------------------------------
	// Result word
	// ----------------------------------------
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
			res_word <= `WORD_RST;
		else if (conv_end)
			res_word <= build_word(result_i, over_range_i, under_range_i);
	end

	// ----------------------------------------
	// Pins
	// ----------------------------------------
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
			sdo_oe_o <= 1'b0;
		else
			sdo_oe_o <= ~cs_s[1];
	end

	// Live done level until the first falling edge, as a host interrupt
	// shifted result
	assign sdo_o = lnk.shift_on ? lnk.sdo_bit : eoc;

	// ----------------------------------------
	// Configuration
	// ----------------------------------------
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			pend_chan <= `CHAN_RST;
			pend_cfg <= `CFG_RST;
		end
		else if (st == adc_port_pkg::ST_OUTPUT && cfg_evt &&
			lnk.cfg_word[`PRE_HI:`PRE_LO] == `PRE_UPDATE)
		begin
			pend_chan <= lnk.cfg_word[`CHAN_HI:`CHAN_LO];
			if (lnk.cfg_word[`EN2_BIT])
				pend_cfg <= lnk.cfg_word[`CFG_HI:`CFG_LO];
		end
	end

	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			channel_sel_o <= `CHAN_RST;
			conv_cfg_o <= `CFG_RST;
		end
		else if (st == adc_port_pkg::ST_START)
		begin
			channel_sel_o <= pend_chan;
			conv_cfg_o <= pend_cfg;
		end
	end

	// ----------------------------------------
	// SCK mode and master clock
	// ----------------------------------------
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
			boot <= 2'h0;
		else if (boot != 2'h3)
			boot <= boot + 2'h1;
	end

	always_ff @(posedge clk_i)
	begin
		if (rst_i)
			slave_mode_o <= 1'b1;
		else if (boot == 2'h2 || cs_fall)
			slave_mode_o <= ~sck_s[1];
	end

	always_ff @(posedge clk_i)
	begin
		if (rst_i || cs_s[1] || slave_mode_o)
		begin
			sck_o <= 1'b0;
			hc <= 4'h0;
			pulses <= 5'h00;
		end
		else if (st == adc_port_pkg::ST_OUTPUT && pulses != `WORD_BITS)
		begin
			if (hc == HALF_LAST)
			begin
				hc <= 4'h0;
				sck_o <= ~sck_o;
				if (sck_o)
					pulses <= pulses + 5'h01;
			end
			else
				hc <= hc + 4'h1;
		end
	end

	always_ff @(posedge clk_i)
	begin
		if (rst_i)
			sck_oe_o <= 1'b0;
		else
			sck_oe_o <= ~slave_mode_o & ~cs_s[1];
	end

	// ----------------------------------------
	// Checks
	// ----------------------------------------
	default clocking cb @(posedge clk_i);
	endclocking
	default disable iff (rst_i);

	sequence s_conv_done;
		st == adc_port_pkg::ST_CONVERT && conv_end;
	endsequence

	sequence s_frame_close;
		st == adc_port_pkg::ST_OUTPUT && !done_evt && cs_rise;
	endsequence

	a_sleep_entry: assert property (s_conv_done ##0 cs_s[1]
		|=> st == adc_port_pkg::ST_SLEEP ##1 !eoc)
		else $error("no sleep after conversion");
	a_ready_low: assert property (s_conv_done ##0 !cs_s[1]
		|=> st == adc_port_pkg::ST_OUTPUT ##1 !eoc && !sdo_o)
		else $error("done not shown low");
	a_restart: assert property (st == adc_port_pkg::ST_OUTPUT &&
		done_evt |=> st == adc_port_pkg::ST_START ##1
		(st == adc_port_pkg::ST_CONVERT && conv_start_o))
		else $error("no conversion after full frame");
	a_abort_start: assert property (s_frame_close ##0
		(started || rise_evt) |=> st == adc_port_pkg::ST_START)
		else $error("abort did not start conversion");
	a_idle_close: assert property (s_frame_close ##0
		!(started || rise_evt) |=> st == adc_port_pkg::ST_SLEEP)
		else $error("unclocked frame left sleep path");
	a_sdo_release: assert property (cs_s[1] |=> !sdo_oe_o)
		else $error("SDO driven while deselected");
	a_over_code: assert property (s_conv_done ##0 over_range_i
		|=> res_word[21:4] == `OVER_CODE && res_word[3:0] == 4'h0)
		else $error("overrange code wrong");
	a_under_code: assert property (s_conv_done ##0
		(!over_range_i && under_range_i)
		|=> res_word[21:20] == 2'h0 && res_word[21:4] == `UNDER_CODE)
		else $error("underrange code wrong");
	a_sign_bit: assert property (s_conv_done ##0
		(!over_range_i && !under_range_i)
		|=> res_word[21] == !$past(result_i[16]) && !res_word[22])
		else $error("sign bit wrong");
	a_cfg_apply: assert property (st == adc_port_pkg::ST_START
		|=> channel_sel_o == $past(pend_chan) &&
		conv_cfg_o == $past(pend_cfg))
		else $error("selection not applied at start");
	a_cfg_keep: assert property (st == adc_port_pkg::ST_OUTPUT &&
		cfg_evt && lnk.cfg_word[`PRE_HI:`PRE_LO] != `PRE_UPDATE
		|=> $stable(pend_chan) && $stable(pend_cfg))
		else $error("selection changed without preamble");
	a_reset_cfg: assert property ($fell(rst_i)
		|-> pend_chan == `CHAN_RST && pend_cfg == `CFG_RST ##1
		conv_start_o)
		else $error("reset selection or first start wrong");

endmodule : adc_serial_result_port

// [adc_serial_result_port_test.sv]
/*
 Self-checking bench of the converter serial result port.
 Assumes the host model owns SCK and a shortened conversion count.
*/
`timescale 1ns/1ps
module adc_serial_result_port_test;
	localparam int CONV = 50;
	logic clk_i = 1'b0;
	logic rst_i = 1'b1;
	logic ext_conversion_clock_i = 1'b0;
	logic ext_clock_sel_i = 1'b0;
	logic [16:0] result_i = 17'h00000;
	logic over_range_i = 1'b0;
	logic under_range_i = 1'b0;
	logic sck_i, sck_o, sck_oe_o, cs_n, sdi, host_sck, sdo_o, sdo_oe_o;
	logic conv_start_o, sleep_o, slave_mode_o, tail;
	adc_port_pkg::chan_t channel_sel_o;
	adc_port_pkg::conv_cfg_t conv_cfg_o;
	int failures = 0;
	int checks_done = 0;
	int starts = 0;
	logic [23:0] exp_w, rd, mask;
	logic [4:0] exp_chan = 5'h00;
	logic [6:0] exp_cfg = 7'h00;

	always #25 clk_i = ~clk_i;
	always #200 ext_conversion_clock_i = ~ext_conversion_clock_i;
	assign sck_i = sck_oe_o ? sck_o : host_sck;

	adc_serial_result_port #(.CONV_CYCLES(CONV)) adc_serial_result_port_inst (
		.clk_i(clk_i), .rst_i(rst_i), .sck_i(sck_i), .sck_o(sck_o),
		.sck_oe_o(sck_oe_o), .cs_n_i(cs_n), .sdi_i(sdi), .sdo_o(sdo_o),
		.sdo_oe_o(sdo_oe_o), .ext_conversion_clock_i(ext_conversion_clock_i),
		.ext_clock_sel_i(ext_clock_sel_i), .result_i(result_i),
		.over_range_i(over_range_i), .under_range_i(under_range_i),
		.conv_start_o(conv_start_o), .sleep_o(sleep_o),
		.slave_mode_o(slave_mode_o), .channel_sel_o(channel_sel_o),
		.conv_cfg_o(conv_cfg_o)
	);

	adc_host_model adc_host_model_inst (
		.sdo_i(sdo_o), .sdo_oe_i(sdo_oe_o), .cs_n_o(cs_n),
		.sck_o(host_sck), .sdi_o(sdi)
	);

	always @(posedge clk_i)
	begin
		if (!rst_i && conv_start_o === 1'b1)
			starts <= starts + 1;
	end

	// ----------------------------------------
	// Expectations and checks
	// ----------------------------------------
	function automatic logic [23:0] expect_word(input logic [16:0] r,
		input logic ov, input logic un);
		logic [17:0] body;
		body = ov ? 18'h30000 : un ? 18'h0ffff : {~r[16], r};
		return {2'b00, body, 4'h0};
	endfunction : expect_word

	task automatic check(input logic [23:0] got, input logic [23:0] want);
		checks_done++;
		if (got !== want)
		begin
			failures++;
			$display("mismatch at %0t ns: got %h expected %h", $time, got, want);
		end
	endtask : check

	task automatic conclude();
		$display("checks %0d mismatches %0d", checks_done, failures);
		if (failures == 0 && checks_done > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask : conclude

	// Result sampled at the end of the conversion now running
	task automatic next_result(input int i);
		@(posedge clk_i);
		#2;
		over_range_i = (i % 4 == 0);
		under_range_i = (i % 4 == 1);
		result_i = (i % 4 == 2) ? 17'h1ffff : 17'($urandom);
		exp_w = expect_word(result_i, over_range_i, under_range_i);
	endtask : next_result

	task automatic wait_ready(output int n);
		n = 0;
		while (!(sdo_oe_o === 1'b1 && sdo_o === 1'b0) && n < 1000)
		begin
			@(posedge clk_i);
			n++;
		end
		@(posedge clk_i);
		#2;
		check(24'(n < 1000), 24'h1);
	endtask : wait_ready

	// ----------------------------------------
	// Tests
	// ----------------------------------------
	initial
	begin
		logic [15:0] cfg;
		logic [2:0] pre;
		int n, s0, wait_n;
		void'($urandom(47221));
		next_result(1);
		repeat (20) @(posedge clk_i);
		#2;
		rst_i = 1'b0;
		repeat (5) @(posedge clk_i);
		#2;
		check(24'({channel_sel_o, conv_cfg_o}), 24'h0);
		check(24'(starts), 24'h1);
		check(24'(slave_mode_o), 24'h1);
		for (int i = 0; i < 14; i++)
		begin
			n = (i == 3) ? 5 : (i == 5) ? 0 : 24;
			case ($urandom_range(2))
				0: pre = 3'h0;
				1: pre = 3'h4;
				default: pre = 3'h5;
			endcase
			cfg = {(i % 2 == 0) ? 3'h5 : pre, 13'($urandom)};
			if (i % 2 == 0)
			begin
				adc_host_model_inst.sck_noise(30);
				check(24'(sdo_oe_o), 24'h0);
				repeat (ext_clock_sel_i ? 450 : 40) @(posedge clk_i);
				#2;
				check(24'(sleep_o), 24'h1);
			end
			adc_host_model_inst.select();
			if (i % 2 == 1)
				check({22'h0, sdo_oe_o, sdo_o}, 24'h3);
			check({21'h0, slave_mode_o, sck_oe_o, sck_o}, 24'h4);
			s0 = starts;
			wait_ready(wait_n);
			if (ext_clock_sel_i && i % 2 == 1)
				check(24'(wait_n > 4 * CONV), 24'h1);
			ext_clock_sel_i = (i >= 9);
			adc_host_model_inst.clock_bits(cfg, n, rd, tail);
			adc_host_model_inst.release_cs();
			mask = ~(24'hffffff >> n);
			check(rd & mask, exp_w & mask);
			if (n == 24)
				check(24'(tail), 24'h1);
			if (n == 24 && cfg[15:13] == 3'h5)
			begin
				exp_chan = cfg[12:8];
				if (cfg[7])
					exp_cfg = cfg[6:0];
			end
			if (n > 0)
				next_result(i + 1);
			repeat (8) @(posedge clk_i);
			#2;
			check(24'(starts - s0), (n > 0) ? 24'h1 : 24'h0);
			check(24'({channel_sel_o, conv_cfg_o}), 24'({exp_chan, exp_cfg}));
			$display("test %0d done", i);
		end
		conclude();
	end

	// Whole run is well under half a millisecond
	initial
	begin
		#1_000_000;
		failures++;
		conclude();
	end
endmodule : adc_serial_result_port_test
